// *** inc/ccbl_defines.svh ***
`ifndef CCBL_DEFINES_SVH
`define CCBL_DEFINES_SVH

// Register byte offsets
`define CCBL_OFF_CMD 12'h000
`define CCBL_OFF_OPND 12'h004
`define CCBL_OFF_ADDR 12'h008
`define CCBL_OFF_RNG 12'h00c
`define CCBL_OFF_REPLY 12'h010
`define CCBL_OFF_STAT 12'h014

// Channel/function word fields
`define CCBL_CF_FC 5:0
`define CCBL_CF_CHAN_LSB 6
`define CCBL_CF_BUSCH 15:10

// Function codes
`define CCBL_FC_RD_RANGE 6'h0c
`define CCBL_FC_RD_STAT 6'h18
`define CCBL_FC_DS_STAT 6'h1c
`define CCBL_FC_DEV_ID 6'h26
`define CCBL_FC_RD_TBL 6'h1e
`define CCBL_FC_NEXT_STAT 6'h1a
`define CCBL_FC_EXT_ID 6'h08
`define CCBL_FC_LOAD 6'h09
`define CCBL_FC_CTL 6'h0f
`define CCBL_FC_WR_TBL 6'h0b

// Transfer control block byte positions
`define CCBL_B_ADR0 0
`define CCBL_B_ADR1 1
`define CCBL_B_ADR2 2
`define CCBL_B_RNG_LO 3
`define CCBL_B_RNG_HI 4
`define CCBL_B_CTL 5
`define CCBL_B_ST_LO 6
`define CCBL_B_ST_HI 7
`define CCBL_BLK_BYTES 8

// Control byte bits (doc bits 8, 9, 10)
`define CCBL_CTL_INT 7
`define CCBL_CTL_VALID 6
`define CCBL_CTL_LAST 5

// Operand layout
`define CCBL_OPND_FORM 16
`define CCBL_OPND_W 17
`define CCBL_RAM_HI 11:8

// Line table
`define CCBL_LT_BYTES 64
`define CCBL_LT_INDEX 6'd55

// Reset values
`define CCBL_STAT_PTR_RST 2'h0
`define CCBL_LOAD_PTR_RST 2'h1

`endif

// *** inc/ccbl_pkg.sv ***
package ccbl_pkg;
	typedef logic [7:0] ccbl_byte_t;
	typedef logic [15:0] ccbl_word_t;
	typedef logic [1:0] ccbl_ptr_t;
	typedef logic [5:0] ccbl_lt_addr_t;
endpackage

// *** rtl/ccbl_line_table.sv ***
`timescale 1ns/100ps
`include "ccbl_defines.svh"
module ccbl_line_table
	import ccbl_pkg::*;
#(
	parameter int NLINE = 8,
	parameter int LW = $clog2(NLINE)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic hw_en_in,
	input wire logic [LW-1:0] hw_line_in,
	input wire ccbl_lt_addr_t hw_addr_in,
	input wire ccbl_byte_t hw_data_in,
	input wire logic bw_en_in,
	input wire logic [LW-1:0] bw_line_in,
	input wire ccbl_lt_addr_t bw_addr_in,
	input wire ccbl_byte_t bw_data_in,
	input wire logic [LW-1:0] rd_line_in,
	output ccbl_byte_t rd_data_out
);
	ccbl_byte_t sel [NLINE];

	genvar g;
	for (g = 0; g < NLINE; g++) begin : g_line
		ccbl_byte_t mem_q [`CCBL_LT_BYTES];
		ccbl_byte_t mem_d [`CCBL_LT_BYTES];

		// Host write lands last, so it wins a same-byte collision
		always_comb begin
			mem_d = mem_q;
			if (bw_en_in && bw_line_in == LW'(g)) begin
				mem_d[bw_addr_in] = bw_data_in;
			end
			if (hw_en_in && hw_line_in == LW'(g)) begin
				mem_d[hw_addr_in] = hw_data_in;
			end
		end

		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				for (int i = 0; i < `CCBL_LT_BYTES; i++) begin
					mem_q[i] <= 8'h00;
				end
			end else begin
				mem_q <= mem_d;
			end
		end

		// Index byte points at the byte returned to the host
		assign sel[g] = mem_q[mem_q[`CCBL_LT_INDEX][5:0]];
	end

	assign rd_data_out = sel[rd_line_in];
endmodule

// *** rtl/ccbl_host_cmd.sv ***
// Behaviour
// - Word holds bus channel, channel, function code
// - Four-block circular list per channel, three pointers
// - Range read returns byte 4 left, 3 right
// - Status read returns bytes 7/6 by variant
// - Status reads zero until block completed
// - Status read leaves status pointer alone
// - Line register 5 left, low byte zero
// - Identification returns adapter type code
// - Table read returns byte indexed by byte 55
// - Byte 55 loadable by host or block write
// - Next status advances pointer, then returns status
// - Previous top block becomes free
// - Extended ID returns line register 0, device ID in word variant
// - Load writes address and range at load pointer
// - Address bytes 0-2, range 3-4, variant order
// - Control form writes byte 5, clears status
// - Address form writes RAM address bits 11:8 to byte 6
// - Control command advances load pointer
// - Interrupt bit raises interrupt on completion
// - Valid bit cleared when block completes
// - Last-block flag drives indicator while active
`timescale 1ns/100ps
`include "ccbl_defines.svh"
module ccbl_host_cmd
	import ccbl_pkg::*;
#(
	parameter int NCH = 16,
	parameter bit WORD_MODE = 1'b0,
	parameter int CW = $clog2(NCH)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic done_in,
	input wire logic [CW-1:0] done_ch_in,
	input wire ccbl_word_t done_stat_in,
	output logic irq_out,
	output logic [CW-1:0] irq_ch_out,
	output logic [NCH-1:0] last_block_indicator_out,
	input wire logic [NCH*8-1:0] lr0_in,
	input wire logic [NCH*8-1:0] lr5_in,
	input wire logic [NCH*16-1:0] dev_id_in,
	input wire logic bmw_en_in,
	input wire logic [CW-2:0] bmw_line_in,
	input wire ccbl_lt_addr_t bmw_addr_in,
	input wire ccbl_byte_t bmw_data_in
);
	localparam int NBLK = NCH * 4;
	localparam int BW = CW + 2;

	// Bus-facing registers
	ccbl_word_t cmd_q, cmd_d;
	logic [`CCBL_OPND_W-1:0] opnd_q, opnd_d;
	logic [23:0] addr_q, addr_d;
	ccbl_word_t rng_q, rng_d;
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;

	// Block list state
	ccbl_byte_t blk_q [NBLK][`CCBL_BLK_BYTES];
	ccbl_byte_t blk_d [NBLK][`CCBL_BLK_BYTES];
	logic [NBLK-1:0] done_q, done_d;
	ccbl_ptr_t sp_q [NCH];
	ccbl_ptr_t sp_d [NCH];
	ccbl_ptr_t lp_q [NCH];
	ccbl_ptr_t lp_d [NCH];
	ccbl_ptr_t ap_q [NCH];
	ccbl_ptr_t ap_d [NCH];
	ccbl_word_t reply_q, reply_d;
	logic bad_q, bad_d;
	logic irq_q, irq_d;
	logic [CW-1:0] irq_ch_q, irq_ch_d;

	logic setup;
	logic access;
	logic mapped;
	logic cmd_go;
	ccbl_word_t cf;
	logic [5:0] fc;
	logic [CW-1:0] ch;
	logic [CW-1:0] ch_q;
	logic [BW-1:0] top;
	logic [BW-1:0] nxt;
	logic [BW-1:0] ld;
	logic [BW-1:0] act;
	logic lt_we;
	ccbl_byte_t lt_rd;

	// Status is hidden until the block completes
	function automatic ccbl_word_t stat_word(input ccbl_byte_t hi,
		input ccbl_byte_t lo, input logic done);
		ccbl_word_t w;
		w = 16'h0000;
		if (done) begin
			w = WORD_MODE ? {lo, hi} : {hi, lo};
		end
		return w;
	endfunction

	assign setup = psel_in && !penable_in;
	assign access = psel_in && penable_in;
	// Zero-wait slave: every access completes in one access cycle
	assign pready_out = 1'b1;
	assign pslverr_out = access && err_q;
	assign prdata_out = rdata_q;

	always_comb begin
		case (paddr_in)
			`CCBL_OFF_CMD,
			`CCBL_OFF_OPND,
			`CCBL_OFF_ADDR,
			`CCBL_OFF_RNG,
			`CCBL_OFF_REPLY,
			`CCBL_OFF_STAT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Command runs at the access edge of a write to the command word
	assign cmd_go = access && pwrite_in && paddr_in == `CCBL_OFF_CMD;
	assign cf = pwdata_in[15:0];
	assign fc = cf[`CCBL_CF_FC];
	assign ch = cf[`CCBL_CF_CHAN_LSB +: CW];
	assign ch_q = cmd_q[`CCBL_CF_CHAN_LSB +: CW];
	assign top = {ch, sp_q[ch]};
	assign nxt = {ch, 2'(sp_q[ch] + 2'h1)};
	assign ld = {ch, lp_q[ch]};
	assign act = {done_ch_in, ap_q[done_ch_in]};
	assign lt_we = cmd_go && fc == `CCBL_FC_WR_TBL;

	ccbl_line_table #(
		.NLINE(NCH / 2),
		.LW(CW - 1)
	) u_table (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.hw_en_in(lt_we),
		.hw_line_in(ch[CW-1:1]),
		.hw_addr_in(opnd_q[5:0]),
		.hw_data_in(opnd_q[15:8]),
		.bw_en_in(bmw_en_in),
		.bw_line_in(bmw_line_in),
		.bw_addr_in(bmw_addr_in),
		.bw_data_in(bmw_data_in),
		.rd_line_in(ch[CW-1:1]),
		.rd_data_out(lt_rd)
	);

	// Bus register group
	always_comb begin
		cmd_d = cmd_q;
		opnd_d = opnd_q;
		addr_d = addr_q;
		rng_d = rng_q;
		rdata_d = rdata_q;
		err_d = err_q;
		if (access && pwrite_in) begin
			case (paddr_in)
				`CCBL_OFF_CMD: cmd_d = cf;
				`CCBL_OFF_OPND: opnd_d = pwdata_in[`CCBL_OPND_W-1:0];
				`CCBL_OFF_ADDR: addr_d = pwdata_in[23:0];
				`CCBL_OFF_RNG: rng_d = pwdata_in[15:0];
				default: ;
			endcase
		end
		if (setup) begin
			err_d = !mapped;
			case (paddr_in)
				`CCBL_OFF_CMD: rdata_d = {16'h0000, cmd_q};
				`CCBL_OFF_OPND: rdata_d = {15'h0000, opnd_q};
				`CCBL_OFF_ADDR: rdata_d = {8'h00, addr_q};
				`CCBL_OFF_RNG: rdata_d = {16'h0000, rng_q};
				`CCBL_OFF_REPLY: rdata_d = {16'h0000, reply_q};
				`CCBL_OFF_STAT: rdata_d = {24'h000000, ap_q[ch_q],
					lp_q[ch_q], sp_q[ch_q], 1'b0, bad_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_q <= 16'h0000;
			opnd_q <= 17'h00000;
			addr_q <= 24'h000000;
			rng_q <= 16'h0000;
			rdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end else begin
			cmd_q <= cmd_d;
			opnd_q <= opnd_d;
			addr_q <= addr_d;
			rng_q <= rng_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// Block list group
	always_comb begin
		blk_d = blk_q;
		done_d = done_q;
		sp_d = sp_q;
		lp_d = lp_q;
		ap_d = ap_q;
		reply_d = reply_q;
		bad_d = bad_q;
		irq_d = 1'b0;
		irq_ch_d = irq_ch_q;
		if (cmd_go) begin
			bad_d = 1'b0;
			case (fc)
				`CCBL_FC_RD_RANGE: begin
					reply_d = {blk_q[top][`CCBL_B_RNG_HI],
						blk_q[top][`CCBL_B_RNG_LO]};
				end
				`CCBL_FC_RD_STAT: begin
					// Pointer untouched so polling can repeat
					reply_d = stat_word(blk_q[top][`CCBL_B_ST_HI],
						blk_q[top][`CCBL_B_ST_LO], done_q[top]);
				end
				`CCBL_FC_NEXT_STAT: begin
					sp_d[ch] = 2'(sp_q[ch] + 2'h1);
					reply_d = stat_word(blk_q[nxt][`CCBL_B_ST_HI],
						blk_q[nxt][`CCBL_B_ST_LO], done_q[nxt]);
					done_d[top] = 1'b0;
					blk_d[top][`CCBL_B_CTL][`CCBL_CTL_VALID] = 1'b0;
				end
				`CCBL_FC_DS_STAT: begin
					reply_d = {lr5_in[ch*8 +: 8], 8'h00};
				end
				`CCBL_FC_DEV_ID: begin
					reply_d = dev_id_in[ch*16 +: 16];
				end
				`CCBL_FC_EXT_ID: begin
					if (WORD_MODE) begin
						reply_d = dev_id_in[ch*16 +: 16];
					end else begin
						reply_d = {lr0_in[ch*8 +: 8], 8'h00};
					end
				end
				`CCBL_FC_RD_TBL: begin
					reply_d = {8'h00, lt_rd};
				end
				`CCBL_FC_WR_TBL: ;
				`CCBL_FC_LOAD: begin
					// Address is byte or word units as the host supplies
					blk_d[ld][`CCBL_B_ADR2] = addr_q[23:16];
					if (WORD_MODE) begin
						blk_d[ld][`CCBL_B_ADR1] = addr_q[7:0];
						blk_d[ld][`CCBL_B_ADR0] = addr_q[15:8];
						blk_d[ld][`CCBL_B_RNG_HI] = rng_q[7:0];
						blk_d[ld][`CCBL_B_RNG_LO] = rng_q[15:8];
					end else begin
						blk_d[ld][`CCBL_B_ADR0] = addr_q[7:0];
						blk_d[ld][`CCBL_B_ADR1] = addr_q[15:8];
						blk_d[ld][`CCBL_B_RNG_LO] = rng_q[7:0];
						blk_d[ld][`CCBL_B_RNG_HI] = rng_q[15:8];
					end
				end
				`CCBL_FC_CTL: begin
					blk_d[ld][`CCBL_B_CTL] = opnd_q[7:0];
					blk_d[ld][`CCBL_B_ST_HI] = 8'h00;
					done_d[ld] = 1'b0;
					if (opnd_q[`CCBL_OPND_FORM]) begin
						blk_d[ld][`CCBL_B_ST_LO] =
							{4'h0, opnd_q[`CCBL_RAM_HI]};
					end else begin
						blk_d[ld][`CCBL_B_ST_LO] = 8'h00;
					end
					lp_d[ch] = 2'(lp_q[ch] + 2'h1);
				end
				default: bad_d = 1'b1;
			endcase
		end
		// Completion applied last: a same-cycle host clear loses
		if (done_in && blk_q[act][`CCBL_B_CTL][`CCBL_CTL_VALID]) begin
			blk_d[act][`CCBL_B_ST_LO] = done_stat_in[7:0];
			blk_d[act][`CCBL_B_ST_HI] = done_stat_in[15:8];
			blk_d[act][`CCBL_B_CTL][`CCBL_CTL_VALID] = 1'b0;
			done_d[act] = 1'b1;
			ap_d[done_ch_in] = 2'(ap_q[done_ch_in] + 2'h1);
			if (blk_q[act][`CCBL_B_CTL][`CCBL_CTL_INT]) begin
				irq_d = 1'b1;
				irq_ch_d = done_ch_in;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int b = 0; b < NBLK; b++) begin
				for (int k = 0; k < `CCBL_BLK_BYTES; k++) begin
					blk_q[b][k] <= 8'h00;
				end
			end
			for (int c = 0; c < NCH; c++) begin
				sp_q[c] <= `CCBL_STAT_PTR_RST;
				lp_q[c] <= `CCBL_LOAD_PTR_RST;
				ap_q[c] <= `CCBL_LOAD_PTR_RST;
			end
			done_q <= '0;
			reply_q <= 16'h0000;
			bad_q <= 1'b0;
			irq_q <= 1'b0;
			irq_ch_q <= '0;
		end else begin
			blk_q <= blk_d;
			sp_q <= sp_d;
			lp_q <= lp_d;
			ap_q <= ap_d;
			done_q <= done_d;
			reply_q <= reply_d;
			bad_q <= bad_d;
			irq_q <= irq_d;
			irq_ch_q <= irq_ch_d;
		end
	end

	assign irq_out = irq_q;
	assign irq_ch_out = irq_ch_q;

	genvar g;
	for (g = 0; g < NCH; g++) begin : g_lbi
		logic [BW-1:0] a;
		assign a = {CW'(g), ap_q[g]};
		assign last_block_indicator_out[g] =
			blk_q[a][`CCBL_B_CTL][`CCBL_CTL_LAST] &&
			blk_q[a][`CCBL_B_CTL][`CCBL_CTL_VALID];
	end
endmodule

// *** testbench/ccbl_line_model.sv ***
`timescale 1ns/100ps
module ccbl_line_model
	import ccbl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic go_in,
	input wire logic [3:0] ch_in,
	input wire ccbl_word_t stat_in,
	output logic done_out,
	output logic [3:0] ch_out,
	output ccbl_word_t stat_out
);
	// Status lines toggle outside a completion so stale data never matches
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			done_out <= 1'b0;
			ch_out <= 4'h0;
			stat_out <= 16'h0000;
		end else begin
			done_out <= go_in;
			ch_out <= go_in ? ch_in : ~ch_out;
			stat_out <= go_in ? stat_in : ~stat_out;
		end
	end
endmodule

// *** testbench/ccbl_host_cmd_asserts.sv ***
`timescale 1ns/100ps
module ccbl_host_cmd_asserts
	import ccbl_pkg::*;
#(
	parameter int NCH = 16,
	parameter int CW = $clog2(NCH)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input logic [31:0] prdata_out,
	input logic pready_out,
	input logic pslverr_out,
	input wire logic done_in,
	input wire logic [CW-1:0] done_ch_in,
	input logic irq_out,
	input logic [CW-1:0] irq_ch_out,
	input logic [NCH-1:0] last_block_indicator_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic acc;
	logic trig;
	assign acc = psel_in && penable_in;
	assign trig = done_in || (acc && pwrite_in);
	ready_high_a: assert property (pready_out)
		else $error("pready low");
	slverr_map_a: assert property (acc |-> pslverr_out ==
		(paddr_in[1:0] != 2'b00 || paddr_in > 12'h014))
		else $error("slave error decode wrong");
	slverr_data_a: assert property (acc && !pwrite_in && pslverr_out |-> prdata_out == 32'h0)
		else $error("unmapped read data not zero");
	rdata_hold_a: assert property (acc |=> $stable(prdata_out))
		else $error("read data moved after access");
	irq_once_a: assert property (irq_out && !done_in |=> !irq_out)
		else $error("interrupt longer than one cycle");
	irq_cause_a: assert property (irq_out |-> $past(done_in))
		else $error("interrupt without completion");
	irq_chan_a: assert property (irq_out |-> irq_ch_out == $past(done_ch_in))
		else $error("interrupt channel wrong");
	irq_hold_a: assert property (!irq_out |-> $stable(irq_ch_out))
		else $error("interrupt channel moved");
	lbi_cause_a: assert property ($changed(last_block_indicator_out) |-> $past(trig) || $past(trig, 2))
		else $error("last block indicator moved alone");
	irq_seen_c: cover property (irq_out);
	err_seen_c: cover property (pslverr_out);
	lbi_seen_c: cover property ($rose(|last_block_indicator_out));
endmodule
bind ccbl_host_cmd ccbl_host_cmd_asserts #(.NCH(NCH), .CW(CW)) i_chk (
	.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
	.prdata_out, .pready_out, .pslverr_out, .done_in, .done_ch_in,
	.irq_out, .irq_ch_out, .last_block_indicator_out
);

// *** testbench/ccbl_host_cmd_test.sv ***
`timescale 1ns/100ps
`include "ccbl_defines.svh"
module ccbl_host_cmd_test;
	import ccbl_pkg::*;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
	logic [11:0] pa = '0;
	logic [31:0] pwd = '0, prd, r, prd_w, rw;
	logic prdy, perr, re, done, irq, go = 0, bmw = 0;
	logic [3:0] dch, ich, gch = '0;
	ccbl_word_t dst, gst = '0;
	logic [15:0] lbi;
	logic [127:0] lr0, lr5;
	logic [255:0] did;
	logic [2:0] bln = '0;
	ccbl_lt_addr_t bad = '0;
	ccbl_byte_t bdt = '0;
	int errors = 0, n_checks = 0;
	initial forever #50 clk = ~clk;
	ccbl_host_cmd i_dut (.clk_in(clk), .rst_in(rst), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
		.done_in(done), .done_ch_in(dch), .done_stat_in(dst), .irq_out(irq),
		.irq_ch_out(ich), .last_block_indicator_out(lbi), .lr0_in(lr0),
		.lr5_in(lr5), .dev_id_in(did), .bmw_en_in(bmw), .bmw_line_in(bln),
		.bmw_addr_in(bad), .bmw_data_in(bdt));
	// Word-addressing variant shares the bus; only its read data is judged
	ccbl_host_cmd #(.WORD_MODE(1'b1)) i_dut_w (.clk_in(clk), .rst_in(rst),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
		.pwdata_in(pwd), .prdata_out(prd_w), .pready_out(),
		.pslverr_out(), .done_in(done), .done_ch_in(dch),
		.done_stat_in(dst), .irq_out(), .irq_ch_out(),
		.last_block_indicator_out(), .lr0_in(lr0), .lr5_in(lr5),
		.dev_id_in(did), .bmw_en_in(bmw), .bmw_line_in(bln),
		.bmw_addr_in(bad), .bmw_data_in(bdt));
	ccbl_line_model i_line (.clk_in(clk), .rst_in(rst), .go_in(go),
		.ch_in(gch), .stat_in(gst), .done_out(done), .ch_out(dch),
		.stat_out(dst));
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			report_and_stop;
		end
		r = prd;
		rw = prd_w;
		re = perr;
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	task cmd(input logic [3:0] c, input logic [5:0] f);
		apb(1, `CCBL_OFF_CMD, {22'h0, c, f});
		apb(0, `CCBL_OFF_REPLY, 32'h0);
	endtask
	task t_ident;
		cmd(3, `CCBL_FC_DS_STAT);
		chk(r, 32'h5300);
		chk(rw, 32'h5300);
		cmd(3, `CCBL_FC_DEV_ID);
		chk(r, 32'h0a03);
		chk(rw, 32'h0a03);
		cmd(3, `CCBL_FC_EXT_ID);
		chk(r, 32'h1300);
		chk(rw, 32'h0a03);
		$display("ident test done");
	endtask
	task t_table;
		apb(1, `CCBL_OFF_OPND, 32'ha50c);
		cmd(3, `CCBL_FC_WR_TBL);
		apb(1, `CCBL_OFF_OPND, 32'h0c37);
		cmd(3, `CCBL_FC_WR_TBL);
		cmd(3, `CCBL_FC_RD_TBL);
		chk(r, 32'h00a5);
		// Line 1 serves channel 3; index then target byte
		bmw <= 1;
		bln <= 3'h1;
		bad <= 6'd55;
		bdt <= 8'h0d;
		@(posedge clk);
		bad <= 6'd13;
		bdt <= 8'h5a;
		@(posedge clk);
		bmw <= 0;
		cmd(3, `CCBL_FC_RD_TBL);
		chk(r, 32'h005a);
		$display("table test done");
	endtask
	task t_list;
		int n;
		apb(1, `CCBL_OFF_ADDR, 32'h123456);
		apb(1, `CCBL_OFF_RNG, 32'h0102);
		cmd(2, `CCBL_FC_LOAD);
		apb(1, `CCBL_OFF_OPND, 32'h00e0);
		cmd(2, `CCBL_FC_CTL);
		chk({31'h0, lbi[2]}, 32'h1);
		apb(0, `CCBL_OFF_STAT, 32'h0);
		chk(r & 32'h3c, 32'h20);
		cmd(2, `CCBL_FC_NEXT_STAT);
		chk(r, 32'h0);
		cmd(2, `CCBL_FC_RD_RANGE);
		chk(r, 32'h0102);
		chk(rw, 32'h0201);
		repeat (2) begin
			cmd(2, `CCBL_FC_RD_STAT);
			chk(r, 32'h0);
		end
		apb(0, `CCBL_OFF_STAT, 32'h0);
		chk(r & 32'h3c, 32'h24);
		go <= 1;
		gch <= 4'h2;
		gst <= 16'hbeef;
		@(posedge clk);
		go <= 0;
		n = 0;
		// Sampled mid-cycle, away from the edge that moves it
		while (irq !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		chk({31'h0, irq}, 32'h1);
		chk({28'h0, ich}, 32'h2);
		repeat (2) @(posedge clk);
		chk({31'h0, lbi[2]}, 32'h0);
		cmd(2, `CCBL_FC_RD_STAT);
		chk(r, 32'hbeef);
		chk(rw, 32'hefbe);
		// Valid block without interrupt request completes silently
		apb(1, `CCBL_OFF_OPND, 32'h0040);
		cmd(2, `CCBL_FC_CTL);
		go <= 1;
		gst <= 16'h1234;
		@(posedge clk);
		go <= 0;
		n = 0;
		repeat (4) begin
			@(negedge clk);
			if (irq !== 1'b0) begin
				n++;
			end
		end
		@(posedge clk);
		chk(n, 0);
		cmd(2, `CCBL_FC_NEXT_STAT);
		chk(r, 32'h1234);
		chk(rw, 32'h3412);
		cmd(2, `CCBL_FC_RD_STAT);
		chk(r, 32'h1234);
		$display("list test done");
	endtask
	task t_errs;
		cmd(2, 6'h3e);
		apb(0, `CCBL_OFF_STAT, 32'h0);
		chk({31'h0, r[0]}, 32'h1);
		chk({31'h0, re}, 32'h0);
		apb(0, 12'h020, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, re}, 32'h1);
		$display("error test done");
	endtask
	initial begin
		for (int c = 0; c < 16; c++) begin
			lr0[c*8+:8] = 8'h10 + 8'(c);
			lr5[c*8+:8] = 8'h50 + 8'(c);
			did[c*16+:16] = 16'h0a00 + 16'(c);
		end
		repeat (8) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_ident;
		t_table;
		t_list;
		t_errs;
		report_and_stop;
	end
endmodule
